// ### analog_input_scaling_curve_test.sv
`timescale 1ns/1ps
module analog_input_scaling_curve_test;
  import asc_pkg::*;
  localparam int STEPS = 10;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, lose = 1, fault, lost, done;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rv;
  logic signed [31:0] val = '0, meas, cin, cout;
  logic meas_ok;
  int errors = 0, total_checks = 0, seed = 32'h21ff, cyc = 0, n;
  longint pin[3] = '{0, 32'h1000, 32'h2000};
  longint pout[3] = '{32'h0123, 32'h5a77, -'sh3301};
  asc_curve #(.STEP_CYCLES(STEPS)) i_asc_curve (.core_clk_i(clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .meas_i(meas), .meas_valid_i(meas_ok),
    .curve_input_range_fault_o(fault), .meas_lost_o(lost), .curve_in_o(cin),
    .curve_out_o(cout), .update_done_o(done));
  asc_meas_src i_asc_meas_src (.core_clk_i(clk), .value_i(val), .lose_i(lose),
    .meas_o(meas), .valid_o(meas_ok));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bwr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic brd(logic [ADDR_W-1:0] a);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 rv = rdata;
  endtask
  // bounded wait; returns cycles spent
  task automatic wait_upd();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) chk("update timeout", 1, 0);
  endtask
  // the sample is taken at a tick, so one update may still show the old one
  task automatic settle(logic signed [31:0] v);
    @(posedge clk) val <= v;
    wait_upd();
    wait_upd();
  endtask
  function automatic longint interp(longint m);
    if (m <= pin[0]) return pout[0];
    for (int k = 0; k < 2; k++)
      if (m <= pin[k+1]) return pout[k] + ((m - pin[k]) * (pout[k+1] - pout[k])) / (pin[k+1] - pin[k]);
    return pout[2];
  endfunction
  function automatic longint rnd(longint v, int md);
    longint fl;
    fl = (v >>> 8) <<< 8;
    case (md)
      1: return fl;
      2: return fl + (((v & 255) != 0) ? 256 : 0);
      3: return ((v + 128) >>> 8) <<< 8;
      default: return v;
    endcase
  endfunction
  logic signed [31:0] rt[4][3] = '{'{32'h80, 0, 0}, '{32'h80, 1, 1}, '{32'h2000, 1, 1},
    '{32'h800, 1, 0}};
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    lose <= 0;
    repeat (3) @(posedge clk);
    brd(OFS_CTRL); chk("ctrl", 0, rv);
    brd(OFS_CYCLE); chk("cycle", 32'(CYCLE_RST), rv);
    brd(OFS_TAU); chk("tau", 32'(TAU_RST), rv);
    brd(OFS_PT_IN + 8'h04); chk("pt2 in", PT_IN1_RST, rv);
    brd(OFS_PT_OUT + 8'h04); chk("pt2 out", 0, rv);
    brd(OFS_USED); chk("used", 0, rv);
    bwr(8'hfc, 32'h5); brd(8'hfc); chk("unmapped", 0, rv);
    bwr(OFS_CYCLE, 0); brd(OFS_CYCLE); chk("cycle min", 1, rv);
    bwr(OFS_CYCLE, 32'd3000); brd(OFS_CYCLE); chk("cycle max", 32'(CYCLE_MAX), rv);
    bwr(OFS_CYCLE, 32'd20);
    settle(32'h0345);
    chk("raw in", 32'h0345, cin);
    chk("default out", 0, cout);
    wait_upd(); chk("update period", 20 * STEPS, n);
    // range flag only with enable set, both limits
    bwr(OFS_MIN, 32'h100);
    bwr(OFS_MAX, 32'h1000);
    foreach (rt[i]) begin
      bwr(OFS_CTRL, rt[i][1] << CTRL_OOR_BIT);
      settle(rt[i][0]);
      chk("fault", rt[i][2], fault);
      brd(OFS_STATUS); chk("status fault", rt[i][2], rv[STAT_FAULT_BIT]);
    end
    // three-point curve, random inputs, every rounding mode
    for (int i = 0; i < 3; i++) begin
      bwr(OFS_PT_IN + 8'(4 * i), 32'(pin[i]));
      bwr(OFS_PT_OUT + 8'(4 * i), 32'(pout[i]));
    end
    bwr(OFS_USED, 32'h1);
    for (int md = 0; md < 4; md++) begin
      bwr(OFS_CTRL, 32'(md) << CTRL_RND_LSB);
      for (int j = 0; j < 7; j++) begin
        settle(j == 0 ? 32'h1000 : ($random(seed) & 32'h2fff));
        chk("curve out", 32'(rnd(interp(longint'(val)), md)), cout);
        brd(OFS_COUT); chk("cout reg", 32'(rnd(interp(longint'(val)), md)), rv);
      end
    end
    // lost signal holds the last good sample
    settle(32'h0300);
    @(posedge clk) lose <= 1;
    wait_upd();
    wait_upd();
    chk("held in", 32'h0300, cin);
    chk("lost flag", 1, lost);
    brd(OFS_CIN); chk("cin reg", 32'h0300, rv);
    @(posedge clk) lose <= 0;
    // filter: halfway step, a held step to 0x1300 is damped
    bwr(OFS_TAU, 32'd40);
    bwr(OFS_CTRL, 32'h1 << CTRL_FILT_BIT);
    settle(32'h1300);
    chk("filtered", 1, (cin > 32'sh0300 && cin < 32'sh1300));
    chk("lost clear", 0, lost);
    conclude();
  end
endmodule // analog_input_scaling_curve_test

// ### asc_curve.sv
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module asc_curve import asc_pkg::*; #(
  parameter int STEP_CYCLES = STEP_CYC
) (
  input  wire logic                     core_clk_i,               // 200 MHz clock
  input  wire logic                     rst_n_i,                  // async reset, active low
  input  wire logic [ADDR_W-1:0]        reg_addr_i,               // register byte address
  input  wire logic [DATA_W-1:0]        reg_wdata_i,              // write data
  input  wire logic                     reg_wr_i,                 // write strobe
  input  wire logic                     reg_rd_i,                 // read strobe
  output logic [DATA_W-1:0]             reg_rdata_o,              // read data, next cycle
  input  wire logic signed [DATA_W-1:0] meas_i,                   // selected measurement
  input  wire logic                     meas_valid_i,             // measurement signal present
  output logic                          curve_input_range_fault_o,// out-of-range flag
  output logic                          meas_lost_o,              // holding last good value
  output logic signed [DATA_W-1:0]      curve_in_o,               // curve input indication
  output logic signed [DATA_W-1:0]      curve_out_o,              // curve output indication
  output logic                          update_done_o             // pulse per new output
);
  typedef struct packed {
    logic                         filt_en;
    logic                         oor_en;
    asc_rnd_t                     rnd;
    logic [NPTS-3:0]              used;
    logic [11:0]                  cycle;
    logic [19:0]                  tau;
    logic [DATA_W-1:0]            in_min;
    logic [DATA_W-1:0]            in_max;
    logic [NPTS-1:0][DATA_W-1:0]  pt_in;
    logic [NPTS-1:0][DATA_W-1:0]  pt_out;
    logic [19:0]                  step_cnt;
    logic [11:0]                  upd_cnt;
    asc_state_t                   state;
    logic [4:0]                   idx;
    logic [4:0]                   prev;
    logic                         have_prev;
    logic [DATA_W-1:0]            held;
    logic [DATA_W-1:0]            cin;
    logic [DATA_W-1:0]            cout;
    logic                         fault;
    logic                         lost;
    logic [DATA_W-1:0]            rdata;
    logic                         div_start;
    logic [63:0]                  div_num;
    logic [DATA_W-1:0]            div_den;
    logic                         upd_done;
    logic [31:0]                  gap;        // clocks since last tick, for the spacing check
    logic                         cyc_wr;     // cycle rewritten since last tick
  } asc_st_t;

  asc_st_t st_ff;
  asc_st_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  logic       div_done;
  logic signed [63:0] div_quo;

  // reset released through two flops so release is clean against the clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  function automatic logic pt_used(input logic [NPTS-3:0] mask, input logic [4:0] i);
    pt_used = (i < 5'd2) ? 1'b1 : mask[5'(i - 5'd2)];
  endfunction

  // index of a word inside a point array, or NPTS when outside it
  function automatic logic [4:0] pt_index(input logic [ADDR_W-1:0] a,
                                          input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = ADDR_W'(a - base);
    pt_index = (a >= base && d[1:0] == 2'b00 && d[ADDR_W-1:2] < ADDR_W'(NPTS)) ?
               5'(d[ADDR_W-1:2]) : 5'(NPTS);
  endfunction

  function automatic logic [DATA_W-1:0] round_val(input logic [DATA_W-1:0] v,
                                                 input asc_rnd_t m);
    logic [DATA_W-1:0] frac_mask;
    frac_mask = DATA_W'((1 << FRAC_W) - 1);
    unique case (m)
      RND_FLOAT:   round_val = v;
      RND_FLOOR:   round_val = v & ~frac_mask;
      RND_CEIL:    round_val = DATA_W'(v + frac_mask) & ~frac_mask;
      RND_NEAREST: round_val = DATA_W'(v + (frac_mask >> 1) + 1'b1) & ~frac_mask;
    endcase
  endfunction

  function automatic logic [63:0] smul(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    smul = {{32{a[DATA_W-1]}}, a} * {{32{b[DATA_W-1]}}, b};
  endfunction

  asc_div #(
    .NUM_W(64),
    .DEN_W(DATA_W)
  ) u_div (
    .core_clk_i(core_clk_i),
    .rst_n_i   (rst_n),
    .start_i   (st_ff.div_start),
    .num_i     (st_ff.div_num),
    .den_i     (st_ff.div_den),
    .done_o    (div_done),
    .quo_o     (div_quo)
  );

  logic [4:0]        wi_in;
  logic [4:0]        wi_out;
  logic [DATA_W-1:0] sample;
  logic [DATA_W-1:0] x0;
  logic [DATA_W-1:0] xi;
  logic              tick;

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.div_start = 1'b0;
    nxt_st.upd_done  = 1'b0;
    nxt_st.rdata     = '0;
    wi_in  = pt_index(reg_addr_i, OFS_PT_IN);
    wi_out = pt_index(reg_addr_i, OFS_PT_OUT);
    sample = meas_valid_i ? meas_i : st_ff.held;
    x0     = st_ff.pt_in[st_ff.prev];
    xi     = st_ff.pt_in[st_ff.idx];
    tick   = 1'b0;

    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_CTRL: begin
          nxt_st.filt_en = reg_wdata_i[CTRL_FILT_BIT];
          nxt_st.oor_en  = reg_wdata_i[CTRL_OOR_BIT];
          nxt_st.rnd     = asc_rnd_t'(reg_wdata_i[CTRL_RND_LSB +: 2]);
        end
        OFS_USED:  nxt_st.used = reg_wdata_i[NPTS-3:0];
        OFS_CYCLE: nxt_st.cycle = (reg_wdata_i[11:0] == 12'h000) ? 12'h001 :
                                  (reg_wdata_i[11:0] > CYCLE_MAX) ? CYCLE_MAX :
                                  reg_wdata_i[11:0];
        OFS_TAU:   nxt_st.tau = (reg_wdata_i[19:0] == 20'h00000) ? 20'h00001 :
                                (reg_wdata_i[19:0] > TAU_MAX) ? TAU_MAX : reg_wdata_i[19:0];
        OFS_MIN:   nxt_st.in_min = reg_wdata_i;
        OFS_MAX:   nxt_st.in_max = reg_wdata_i;
        default: begin
          if (wi_in != 5'(NPTS)) nxt_st.pt_in[wi_in] = reg_wdata_i;
          if (wi_out != 5'(NPTS)) nxt_st.pt_out[wi_out] = reg_wdata_i;
        end
      endcase
    end

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_CTRL:   nxt_st.rdata = DATA_W'({st_ff.rnd, st_ff.oor_en, st_ff.filt_en});
        OFS_USED:   nxt_st.rdata = DATA_W'(st_ff.used);
        OFS_CYCLE:  nxt_st.rdata = DATA_W'(st_ff.cycle);
        OFS_TAU:    nxt_st.rdata = DATA_W'(st_ff.tau);
        OFS_MIN:    nxt_st.rdata = st_ff.in_min;
        OFS_MAX:    nxt_st.rdata = st_ff.in_max;
        OFS_CIN:    nxt_st.rdata = st_ff.cin;
        OFS_COUT:   nxt_st.rdata = st_ff.cout;
        OFS_STATUS: nxt_st.rdata = DATA_W'({st_ff.lost, st_ff.fault});
        default: begin
          if (wi_in != 5'(NPTS)) nxt_st.rdata = st_ff.pt_in[wi_in];
          else if (wi_out != 5'(NPTS)) nxt_st.rdata = st_ff.pt_out[wi_out];
        end
      endcase
    end

    // 5 ms step base and update cycle counter
    if (st_ff.step_cnt == 20'(STEP_CYCLES - 1)) begin
      nxt_st.step_cnt = '0;
      if (st_ff.upd_cnt >= st_ff.cycle - 12'h001) begin
        nxt_st.upd_cnt = '0;
        tick           = 1'b1;
      end else begin
        nxt_st.upd_cnt = st_ff.upd_cnt + 12'h001;
      end
    end else begin
      nxt_st.step_cnt = st_ff.step_cnt + 20'h00001;
    end
    nxt_st.gap    = tick ? 32'h0000_0000 : st_ff.gap + 32'h0000_0001;
    nxt_st.cyc_wr = !tick && (st_ff.cyc_wr || (reg_wr_i && reg_addr_i == OFS_CYCLE));

    unique case (st_ff.state)
      ST_IDLE: begin
        // a tick during a long calculation is skipped, not queued
        if (tick) begin
          nxt_st.held = sample;
          nxt_st.lost = !meas_valid_i;
          if (!st_ff.filt_en || {8'h00, st_ff.cycle} >= st_ff.tau) begin
            nxt_st.cin   = sample;
            nxt_st.state = ST_SEARCH;
          end else begin
            nxt_st.div_num   = smul(DATA_W'(sample - st_ff.cin), DATA_W'(st_ff.cycle));
            nxt_st.div_den   = DATA_W'(st_ff.tau);
            nxt_st.div_start = 1'b1;
            nxt_st.state     = ST_FILT;
          end
          nxt_st.idx       = '0;
          nxt_st.have_prev = 1'b0;
        end
      end
      ST_FILT: begin
        if (div_done) begin
          nxt_st.cin   = DATA_W'(st_ff.cin + div_quo[DATA_W-1:0]);
          nxt_st.state = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        // one point per clock; points assumed ordered by rising input
        if (pt_used(st_ff.used, st_ff.idx)) begin
          if (signed'(st_ff.cin) <= signed'(xi)) begin
            if (!st_ff.have_prev || signed'(xi) == signed'(x0)) begin
              nxt_st.cout  = st_ff.pt_out[st_ff.idx];
              nxt_st.state = ST_OUT;
            end else begin
              nxt_st.div_num   = smul(DATA_W'(st_ff.cin - x0),
                                      DATA_W'(st_ff.pt_out[st_ff.idx] - st_ff.pt_out[st_ff.prev]));
              nxt_st.div_den   = DATA_W'(xi - x0);
              nxt_st.div_start = 1'b1;
              nxt_st.state     = ST_INTERP;
            end
          end else begin
            nxt_st.prev      = st_ff.idx;
            nxt_st.have_prev = 1'b1;
          end
        end
        if (nxt_st.state == ST_SEARCH) begin
          if (st_ff.idx == 5'(NPTS - 1)) begin
            // above the last used point: hold its output
            nxt_st.cout  = pt_used(st_ff.used, st_ff.idx) ? st_ff.pt_out[st_ff.idx] :
                           st_ff.pt_out[st_ff.prev];
            nxt_st.state = ST_OUT;
          end else begin
            nxt_st.idx = st_ff.idx + 5'd1;
          end
        end
      end
      ST_INTERP: begin
        if (div_done) begin
          nxt_st.cout  = DATA_W'(st_ff.pt_out[st_ff.prev] + div_quo[DATA_W-1:0]);
          nxt_st.state = ST_OUT;
        end
      end
      ST_OUT: begin
        nxt_st.cout     = round_val(st_ff.cout, st_ff.rnd);
        nxt_st.upd_done = 1'b1;
        nxt_st.state    = ST_IDLE;
      end
    endcase

    nxt_st.fault = st_ff.oor_en &&
                   (signed'(st_ff.cin) < signed'(st_ff.in_min) ||
                    signed'(st_ff.cin) > signed'(st_ff.in_max));
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.rnd      <= RND_FLOAT;
      st_ff.cycle    <= CYCLE_RST;
      st_ff.tau      <= TAU_RST;
      st_ff.pt_in[1] <= PT_IN1_RST;
      st_ff.state    <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o               = st_ff.rdata;
  assign curve_input_range_fault_o = st_ff.fault;
  assign meas_lost_o               = st_ff.lost;
  assign curve_in_o                = st_ff.cin;
  assign curve_out_o               = st_ff.cout;
  assign update_done_o             = st_ff.upd_done;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  property p_oor_off;
    !st_ff.oor_en |=> !curve_input_range_fault_o;
  endproperty
  a_oor_off: assert property (p_oor_off) else $error("fault raised while disabled");

  property p_below_min;
    st_ff.oor_en && signed'(st_ff.cin) < signed'(st_ff.in_min) |=> curve_input_range_fault_o;
  endproperty
  a_below_min: assert property (p_below_min) else $error("fault missing below min");

  property p_above_max;
    st_ff.oor_en && signed'(st_ff.cin) > signed'(st_ff.in_max) |=> curve_input_range_fault_o;
  endproperty
  a_above_max: assert property (p_above_max) else $error("fault missing above max");

  sequence s_lost_sample;
    st_ff.state == ST_IDLE && tick && !meas_valid_i && !st_ff.filt_en;
  endsequence
  property p_hold_lost;
    logic [DATA_W-1:0] h;
    (s_lost_sample, h = st_ff.held) |=> curve_in_o == h && meas_lost_o;
  endproperty
  a_hold_lost: assert property (p_hold_lost) else $error("lost input not held");

  // a rewritten cycle can shorten or lengthen one period, so that one period is not checked
  property p_tick_spacing;
    tick && !st_ff.cyc_wr |-> st_ff.gap == 32'(st_ff.cycle) * 32'(STEP_CYCLES) - 32'h0000_0001;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("update off cycle");

  property p_floor_fmt;
    st_ff.state == ST_OUT && st_ff.rnd == RND_FLOOR |=> curve_out_o[FRAC_W-1:0] == '0;
  endproperty
  a_floor_fmt: assert property (p_floor_fmt) else $error("floor left a fraction");

  sequence s_raw_sample;
    st_ff.state == ST_IDLE && tick && meas_valid_i && !st_ff.filt_en;
  endsequence
  property p_raw_feed;
    logic [DATA_W-1:0] m;
    (s_raw_sample, m = meas_i) |=> curve_in_o == m && st_ff.state == ST_SEARCH;
  endproperty
  a_raw_feed: assert property (p_raw_feed) else $error("raw input not passed");

  property p_out_changes;
    curve_out_o != $past(curve_out_o) |-> $past(st_ff.state) inside {ST_SEARCH, ST_INTERP, ST_OUT};
  endproperty
  a_out_changes: assert property (p_out_changes) else $error("output changed idle");

  property p_done_follows;
    update_done_o |-> $past(st_ff.state) == ST_OUT && st_ff.state == ST_IDLE;
  endproperty
  a_done_follows: assert property (p_done_follows) else $error("stray done pulse");
endmodule // asc_curve

// ### asc_div.sv
`timescale 1ns/1ps
module asc_div import asc_pkg::*; #(
  parameter int NUM_W = 64,
  parameter int DEN_W = 32
) (
  input  wire logic                    core_clk_i,  // clock
  input  wire logic                    rst_n_i,     // synchronised reset, active low
  input  wire logic                    start_i,     // one-cycle start
  input  wire logic signed [NUM_W-1:0] num_i,       // dividend
  input  wire logic signed [DEN_W-1:0] den_i,       // divisor, nonzero
  output logic                         done_o,      // one-cycle done
  output logic signed [NUM_W-1:0]      quo_o        // quotient, toward zero
);
  typedef struct packed {
    logic             busy;
    logic [6:0]       cnt;
    logic [DEN_W:0]   rem;
    logic [NUM_W-1:0] quo;
    logic [DEN_W-1:0] den;
    logic             neg;
    logic             done;
  } asc_div_st_t;

  asc_div_st_t st_ff;
  asc_div_st_t nxt_st;
  logic [DEN_W+1:0] shifted;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    shifted     = {st_ff.rem, st_ff.quo[NUM_W-1]};
    if (start_i) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = 7'(NUM_W);
      nxt_st.rem  = '0;
      nxt_st.quo  = num_i[NUM_W-1] ? NUM_W'(-num_i) : num_i;
      nxt_st.den  = den_i[DEN_W-1] ? DEN_W'(-den_i) : den_i;
      nxt_st.neg  = num_i[NUM_W-1] ^ den_i[DEN_W-1];
    end else if (st_ff.busy) begin
      // restoring step, one quotient bit per clock
      if (shifted >= {2'b00, st_ff.den}) begin
        nxt_st.rem = (DEN_W+1)'(shifted - {2'b00, st_ff.den});
        nxt_st.quo = {st_ff.quo[NUM_W-2:0], 1'b1};
      end else begin
        nxt_st.rem = shifted[DEN_W:0];
        nxt_st.quo = {st_ff.quo[NUM_W-2:0], 1'b0};
      end
      nxt_st.cnt = st_ff.cnt - 7'h01;
      if (st_ff.cnt == 7'h01) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_o = st_ff.done;
  assign quo_o  = st_ff.neg ? NUM_W'(-st_ff.quo) : st_ff.quo;
endmodule // asc_div

// ### asc_meas_src.sv
`timescale 1ns/1ps
module asc_meas_src (
  input  wire logic               core_clk_i,  // bench clock
  input  wire logic signed [31:0] value_i,     // value to present
  input  wire logic               lose_i,      // break the signal
  output logic signed [31:0]      meas_o,      // measurement line
  output logic                    valid_o      // signal present
);
  initial begin
    meas_o  = '0;
    valid_o = 1'b0;
  end
  // a broken line toggles each clock between the inverted and the last good value
  always @(posedge core_clk_i) begin
    valid_o <= !lose_i;
    meas_o  <= lose_i ? ~meas_o : value_i;
  end
endmodule // asc_meas_src

// ### asc_pkg.sv
package asc_pkg;
  localparam int DATA_W = 32;
  localparam int FRAC_W = 8;                 // value format: signed, 8 fraction bits
  localparam int NPTS   = 20;
  localparam int ADDR_W = 8;

  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_MS       = 5;
  localparam int STEP_CYC      = STEP_MS * 1000000 / CLK_PERIOD_NS;

  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_USED   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CYCLE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TAU    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MIN    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MAX    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CIN    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_COUT   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PT_IN  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_PT_OUT = 8'h90;

  localparam int CTRL_FILT_BIT = 0;
  localparam int CTRL_OOR_BIT  = 1;
  localparam int CTRL_RND_LSB  = 2;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_LOST_BIT  = 1;

  localparam logic [11:0] CYCLE_RST  = 12'h01e;    // 150 ms in 5 ms steps
  localparam logic [11:0] CYCLE_MAX  = 12'h7d0;    // 10 000 ms
  localparam logic [19:0] TAU_RST    = 20'h000c8;  // 1 s in 5 ms steps
  localparam logic [19:0] TAU_MAX    = 20'hb98c0;  // 3800 s
  localparam logic [31:0] PT_IN1_RST = 32'h0000_0100; // 1.0

  typedef enum logic [1:0] {
    RND_FLOAT,
    RND_FLOOR,
    RND_CEIL,
    RND_NEAREST
  } asc_rnd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FILT,
    ST_SEARCH,
    ST_INTERP,
    ST_OUT
  } asc_state_t;
endpackage
